/* File: logic/sfc_defs.vh */
// Register map, field layout and reset values of the streaming buffer
`ifndef SFC_DEFS_VH
`define SFC_DEFS_VH

// Register word offsets on the main register port; the sink-side and source-side ports map only word 0
`define SFC_OFF_OCC       3'h0
`define SFC_OFF_RSVD      3'h1
`define SFC_OFF_HWM       3'h2
`define SFC_OFF_LWM       3'h3
`define SFC_OFF_EFC       3'h4
`define SFC_OFF_DISCARD   3'h5

// Register widths and field layout
`define SFC_REG_W         32
`define SFC_ADDR_W        3
`define SFC_OCC_W         24
`define SFC_CHAN_W        8
`define SFC_DISCARD_BIT   0

// Reset values (high_water_mark resets to depth minus one, derived in the core)
`define SFC_OCC_RST       32'h0000_0000
`define SFC_LWM_RST       32'h0000_0000
`define SFC_EFC_RST       32'h0000_0000
`define SFC_DISCARD_RST   1'b0
`define SFC_UNMAPPED_VAL  32'h0000_0000

// Default build values
`define SFC_DEF_MAX_CHAN  8'hff
`define SFC_DEF_SYNC_LEN  2

`endif

/* File: logic/sfc_level_flag.v */
// Registered level comparator for the near-full and near-empty status flags
`timescale 1ns/1ps
`include "sfc_defs.vh"
module sfc_level_flag #(
  parameter ABOVE = 1
) (
  input  wire                   core_clk_in,
  input  wire                   srst_in,
  input  wire [`SFC_OCC_W-1:0]  level_in,
  input  wire [`SFC_REG_W-1:0]  mark_in,
  output reg                    flag_out
);

  wire [`SFC_REG_W-1:0] level_ext;

  assign level_ext = {{(`SFC_REG_W-`SFC_OCC_W){1'b0}}, level_in};

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      flag_out <= (ABOVE != 0) ? 1'b0 : 1'b1;
    end else if (ABOVE != 0) begin
      flag_out <= (level_ext >= mark_in);
    end else begin
      flag_out <= (level_ext <= mark_in);
    end
  end

endmodule // sfc_level_flag

/* File: logic/sfc_ptr_chain.v */
// Registered delay chain that carries a buffer pointer to the far side
`timescale 1ns/1ps
module sfc_ptr_chain #(
  parameter WIDTH  = 5,
  parameter STAGES = 2
) (
  input  wire             core_clk_in,
  input  wire             srst_in,
  input  wire [WIDTH-1:0] ptr_in,
  output wire [WIDTH-1:0] ptr_out
);

  // Newest pointer enters at the low end; one driver for the whole chain
  reg [WIDTH*STAGES-1:0] chain_q;

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      chain_q <= {(WIDTH*STAGES){1'b0}};
    end else begin
      chain_q <= {chain_q[WIDTH*(STAGES-1)-1:0], ptr_in};
    end
  end

  assign ptr_out = chain_q[WIDTH*STAGES-1:WIDTH*(STAGES-1)];

endmodule // sfc_ptr_chain

/* File: logic/sfc_stream_fifo.v */
// Streaming FIFO with packet modes, status flags and register ports
//
// Function
// RULE_01: Sink and source sides each own pointers; cross-side views pass internal chains.
// RULE_02: Channel number travels with each beat; up to 255 channels.
// RULE_03: Registers are 32 bits: occupancy readable, thresholds writable.
// RULE_04: Default mode: source valid whenever a stored beat is available.
// RULE_05: Store-and-forward: source valid stays low until a whole packet is stored.
// RULE_06: With discard set in store-and-forward, packets seen with error are dropped.
// RULE_07: early_forward_count zero selects store-and-forward; nonzero selects cut-through.
// RULE_08: Cut-through starts at threshold occupancy, then forwards to packet end.
// RULE_09: Source-side occupancy counts output stage; sink-side occupancy does not.
// RULE_10: Depth minus sink-side occupancy equals free write space.
// RULE_11: near_full_flag high when occupancy is at or above high_water_mark.
// RULE_12: near_empty_flag high when occupancy is at or below low_water_mark.
// RULE_13: Data width is bits per symbol times symbols per beat, each 1 to 32.
// RULE_14: Error sideband of 0 to 32 bits is stored and forwarded per beat.
// RULE_15: Storage depth is a power of two; output register adds one entry.
// RULE_16: Occupancy at word 0 is read-only, resets to 0, bits 23:0.
// RULE_17: high_water_mark word 2 resets depth minus one; low_water_mark word 3 resets 0.
// RULE_18: Pointer chains to the far side are 2 to 8 stages long.
// RULE_19: A maximum channel number from 1 to 255 may be configured.
// RULE_20: Separate sink-side and source-side register ports report their occupancy at word 0.
// RULE_21: Zero ready latency; a beat moves only when valid and ready are high.
// RULE_22: Reserved word 1 reads zero and ignores writes.
`timescale 1ns/1ps
`include "sfc_defs.vh"
module sfc_stream_fifo #(
  parameter BITS_PER_SYMBOL  = 8,
  parameter SYMBOLS_PER_BEAT = 4,
  parameter DATA_W           = BITS_PER_SYMBOL * SYMBOLS_PER_BEAT,
  parameter ERROR_WIDTH      = 1,
  parameter ERR_PW           = (ERROR_WIDTH > 0) ? ERROR_WIDTH : 1,
  parameter EMPTY_WIDTH      = 2,
  parameter ADDR_W           = 4,
  parameter USE_PACKETS      = 1,
  parameter [7:0] MAX_CHANNEL = `SFC_DEF_MAX_CHAN,
  parameter SYNC_STAGES      = `SFC_DEF_SYNC_LEN
) (
  input  wire                     core_clk_in,
  input  wire                     srst_in,
  // Sink side
  input  wire                     sink_valid_in,
  output wire                     sink_ready_out,
  input  wire [DATA_W-1:0]        sink_data_in,
  input  wire [`SFC_CHAN_W-1:0]   sink_channel_in,
  input  wire [ERR_PW-1:0]        sink_error_in,
  input  wire                     sink_sop_in,
  input  wire                     sink_eop_in,
  input  wire [EMPTY_WIDTH-1:0]   sink_empty_in,
  // Source side
  output wire                     source_valid_out,
  input  wire                     source_ready_in,
  output reg  [DATA_W-1:0]        source_data_out,
  output reg  [`SFC_CHAN_W-1:0]   source_channel_out,
  output reg  [ERR_PW-1:0]        source_error_out,
  output reg                      source_sop_out,
  output reg                      source_eop_out,
  output reg  [EMPTY_WIDTH-1:0]   source_empty_out,
  // Main register port
  input  wire [`SFC_ADDR_W-1:0]   csr_address_in,
  input  wire                     csr_read_in,
  input  wire                     csr_write_in,
  input  wire [`SFC_REG_W-1:0]    csr_writedata_in,
  output reg  [`SFC_REG_W-1:0]    csr_readdata_out,
  // Sink-side occupancy port
  input  wire [`SFC_ADDR_W-1:0]   snk_regs_address_in,
  input  wire                     snk_regs_read_in,
  output reg  [`SFC_REG_W-1:0]    snk_regs_readdata_out,
  // Source-side occupancy port
  input  wire [`SFC_ADDR_W-1:0]   src_regs_address_in,
  input  wire                     src_regs_read_in,
  output reg  [`SFC_REG_W-1:0]    src_regs_readdata_out,
  // Status
  output wire                     near_full_flag_out,
  output wire                     near_empty_flag_out
);

  localparam DEPTH = 1 << ADDR_W; // RULE_15
  localparam PW    = ADDR_W + 1;
  localparam WORD_W = DATA_W + `SFC_CHAN_W + ERR_PW + EMPTY_WIDTH + 2;
  localparam [`SFC_REG_W-1:0] HWM_RST = DEPTH - 1;
  localparam [`SFC_OCC_W-PW-1:0] OCC_PAD = {(`SFC_OCC_W-PW){1'b0}};

  // Field positions inside one stored word
  localparam P_CHAN  = DATA_W;
  localparam P_ERR   = P_CHAN + `SFC_CHAN_W;
  localparam P_EMPTY = P_ERR + ERR_PW;
  localparam P_SOP   = P_EMPTY + EMPTY_WIDTH;
  localparam P_EOP   = P_SOP + 1;

  // Storage array, no reset: contents are only read behind valid pointers
  reg [WORD_W-1:0] mem_q [0:DEPTH-1];

  reg  [PW-1:0]          wr_ptr_q;
  reg  [PW-1:0]          wr_commit_q;
  reg  [PW-1:0]          rd_ptr_q;
  reg  [PW-1:0]          pkt_cnt_q;
  reg                    err_seen_q;
  reg                    in_pkt_q;
  reg                    out_valid_q;
  reg  [`SFC_REG_W-1:0]  hwm_q;
  reg  [`SFC_REG_W-1:0]  lwm_q;
  reg  [`SFC_REG_W-1:0]  efc_q;
  reg                    discard_q;

  reg  [PW-1:0]          wr_ptr_d;
  reg  [PW-1:0]          wr_commit_d;
  reg                    load_ok;

  wire [PW-1:0]          used_wr;
  wire [PW-1:0]          used_rd;
  wire                   full;
  wire                   accept;
  wire                   chan_ok;
  wire                   wr_en;
  wire                   err_beat;
  wire                   bad_pkt;
  wire                   sf_mode;
  wire                   ct_mode;
  wire                   drop_mode;
  wire                   drop_now;
  wire                   pkt_inc;
  wire                   pkt_dec;
  wire                   load;
  wire [WORD_W-1:0]      wr_word;
  wire [WORD_W-1:0]      rd_word;
  wire [`SFC_OCC_W-1:0]  occ;
  wire [`SFC_OCC_W-1:0]  snk_occ;
  wire [`SFC_OCC_W-1:0]  src_occ;
  wire [PW-1:0]          rd_ptr_far;
  wire [PW-1:0]          wr_commit_far;

  // Write side

  assign used_wr        = wr_ptr_q - rd_ptr_q;
  assign full           = used_wr[ADDR_W];
  assign sink_ready_out = ~full;
  assign accept         = sink_valid_in & ~full; // RULE_21
  assign chan_ok        = (sink_channel_in <= MAX_CHANNEL); // RULE_19
  // Beats above the configured channel limit are taken and thrown away
  assign wr_en          = accept & chan_ok;
  assign err_beat       = (ERROR_WIDTH > 0) ? (|sink_error_in) : 1'b0;
  assign bad_pkt        = err_seen_q | err_beat;

  assign sf_mode   = (USE_PACKETS != 0) && (efc_q == `SFC_EFC_RST); // RULE_07
  assign ct_mode   = (USE_PACKETS != 0) && (efc_q != `SFC_EFC_RST); // RULE_07
  assign drop_mode = sf_mode & discard_q;
  assign drop_now  = wr_en & sink_eop_in & drop_mode & bad_pkt; // RULE_06

  // RULE_02 RULE_13 RULE_14
  assign wr_word = {sink_eop_in, sink_sop_in, sink_empty_in, sink_error_in,
                    sink_channel_in, sink_data_in};

  always @* begin
    wr_ptr_d    = wr_ptr_q;
    wr_commit_d = wr_commit_q;
    if (drop_now) begin
      // Rewind over the bad packet; the reader never saw any of it
      wr_ptr_d = wr_commit_q; // RULE_06
    end else if (wr_en) begin
      wr_ptr_d = wr_ptr_q + {{(PW-1){1'b0}}, 1'b1};
    end
    if (!drop_mode) begin
      wr_commit_d = wr_ptr_d;
    end else if (wr_en && sink_eop_in && !bad_pkt) begin
      wr_commit_d = wr_ptr_d;
    end
  end

  always @(posedge core_clk_in) begin
    if (wr_en) begin
      mem_q[wr_ptr_q[ADDR_W-1:0]] <= wr_word;
    end
  end

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      wr_ptr_q    <= {PW{1'b0}};
      wr_commit_q <= {PW{1'b0}};
      err_seen_q  <= 1'b0;
    end else begin
      wr_ptr_q    <= wr_ptr_d;
      wr_commit_q <= wr_commit_d;
      if (wr_en) begin
        err_seen_q <= sink_eop_in ? 1'b0 : (err_seen_q | err_beat);
      end
    end
  end

  // Complete packets waiting in the array, used to hold back store-and-forward
  assign pkt_inc = (USE_PACKETS != 0) & wr_en & sink_eop_in & ~drop_now;
  assign pkt_dec = (USE_PACKETS != 0) & load & rd_word[P_EOP];

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      pkt_cnt_q <= {PW{1'b0}};
    end else if (pkt_inc && !pkt_dec) begin
      pkt_cnt_q <= pkt_cnt_q + {{(PW-1){1'b0}}, 1'b1};
    end else if (pkt_dec && !pkt_inc) begin
      pkt_cnt_q <= pkt_cnt_q - {{(PW-1){1'b0}}, 1'b1};
    end
  end

  // Read side

  assign used_rd = wr_commit_q - rd_ptr_q;
  assign rd_word = mem_q[rd_ptr_q[ADDR_W-1:0]];
  assign occ     = {OCC_PAD, used_wr} + {{(`SFC_OCC_W-1){1'b0}}, out_valid_q}; // RULE_15

  always @* begin
    if (sf_mode) begin
      load_ok = (pkt_cnt_q != {PW{1'b0}}); // RULE_05
    end else if (ct_mode) begin
      // Once a packet is under way it runs to its end regardless of level
      load_ok = in_pkt_q | ({8'h00, occ} >= efc_q); // RULE_08
    end else begin
      load_ok = 1'b1; // RULE_04
    end
  end

  assign load = (used_rd != {PW{1'b0}}) & load_ok & (~out_valid_q | source_ready_in);

  assign source_valid_out = out_valid_q; // RULE_04

  // Output pipeline register, one extra entry of capacity
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      rd_ptr_q           <= {PW{1'b0}};
      out_valid_q        <= 1'b0;
      in_pkt_q           <= 1'b0;
      source_data_out    <= {DATA_W{1'b0}};
      source_channel_out <= {`SFC_CHAN_W{1'b0}};
      source_error_out   <= {ERR_PW{1'b0}};
      source_sop_out     <= 1'b0;
      source_eop_out     <= 1'b0;
      source_empty_out   <= {EMPTY_WIDTH{1'b0}};
    end else if (load) begin
      rd_ptr_q           <= rd_ptr_q + {{(PW-1){1'b0}}, 1'b1};
      out_valid_q        <= 1'b1;
      in_pkt_q           <= ~rd_word[P_EOP]; // RULE_08
      source_data_out    <= rd_word[DATA_W-1:0]; // RULE_13
      source_channel_out <= rd_word[P_ERR-1:P_CHAN]; // RULE_02
      source_error_out   <= rd_word[P_EMPTY-1:P_ERR]; // RULE_14
      source_empty_out   <= rd_word[P_SOP-1:P_EMPTY];
      source_sop_out     <= rd_word[P_SOP];
      source_eop_out     <= rd_word[P_EOP];
    end else if (source_ready_in) begin
      out_valid_q <= 1'b0; // RULE_21
    end
  end

  // Side views: each side sees the other's pointer only after the chain delay

  sfc_ptr_chain #(
    .WIDTH  (PW),
    .STAGES (SYNC_STAGES)
  ) u_rd_chain (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .ptr_in      (rd_ptr_q),
    .ptr_out     (rd_ptr_far)
  ); // RULE_01 RULE_18

  sfc_ptr_chain #(
    .WIDTH  (PW),
    .STAGES (SYNC_STAGES)
  ) u_wr_chain (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .ptr_in      (wr_commit_q),
    .ptr_out     (wr_commit_far)
  ); // RULE_01 RULE_18

  // Sink view may read high for a few cycles, never low: safe for write pacing
  assign snk_occ = {OCC_PAD, wr_ptr_q - rd_ptr_far}; // RULE_09 RULE_10
  assign src_occ = {OCC_PAD, wr_commit_far - rd_ptr_q} +
                   {{(`SFC_OCC_W-1){1'b0}}, out_valid_q}; // RULE_09

  // Status flags

  sfc_level_flag #(
    .ABOVE (1)
  ) u_near_full (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .level_in    (occ),
    .mark_in     (hwm_q),
    .flag_out    (near_full_flag_out)
  ); // RULE_11

  sfc_level_flag #(
    .ABOVE (0)
  ) u_near_empty (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .level_in    (occ),
    .mark_in     (lwm_q),
    .flag_out    (near_empty_flag_out)
  ); // RULE_12

  // Main register port: writes take effect at the edge, reads answer next cycle

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      hwm_q     <= HWM_RST; // RULE_17
      lwm_q     <= `SFC_LWM_RST; // RULE_17
      efc_q     <= `SFC_EFC_RST;
      discard_q <= `SFC_DISCARD_RST;
    end else if (csr_write_in) begin
      if (csr_address_in == `SFC_OFF_HWM) begin
        hwm_q <= csr_writedata_in; // RULE_03
      end else if (csr_address_in == `SFC_OFF_LWM) begin
        lwm_q <= csr_writedata_in; // RULE_03
      end else if (csr_address_in == `SFC_OFF_EFC) begin
        efc_q <= csr_writedata_in; // RULE_07
      end else if (csr_address_in == `SFC_OFF_DISCARD) begin
        discard_q <= csr_writedata_in[`SFC_DISCARD_BIT]; // RULE_06
      end
      // Word 0 is read-only and word 1 is reserved: writes fall through
    end // RULE_22
  end

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      csr_readdata_out <= `SFC_OCC_RST;
    end else if (csr_read_in) begin
      if (csr_address_in == `SFC_OFF_OCC) begin
        csr_readdata_out <= {8'h00, occ}; // RULE_16
      end else if (csr_address_in == `SFC_OFF_RSVD) begin
        csr_readdata_out <= `SFC_UNMAPPED_VAL; // RULE_22
      end else if (csr_address_in == `SFC_OFF_HWM) begin
        csr_readdata_out <= hwm_q;
      end else if (csr_address_in == `SFC_OFF_LWM) begin
        csr_readdata_out <= lwm_q;
      end else if (csr_address_in == `SFC_OFF_EFC) begin
        csr_readdata_out <= efc_q;
      end else if (csr_address_in == `SFC_OFF_DISCARD) begin
        csr_readdata_out <= {31'h0000_0000, discard_q};
      end else begin
        csr_readdata_out <= `SFC_UNMAPPED_VAL;
      end
    end
  end

  // Per-side occupancy ports: only word 0 is mapped

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      snk_regs_readdata_out <= `SFC_OCC_RST;
      src_regs_readdata_out <= `SFC_OCC_RST;
    end else begin
      if (snk_regs_read_in) begin
        if (snk_regs_address_in == `SFC_OFF_OCC) begin
          snk_regs_readdata_out <= {8'h00, snk_occ}; // RULE_20
        end else begin
          snk_regs_readdata_out <= `SFC_UNMAPPED_VAL;
        end
      end
      if (src_regs_read_in) begin
        if (src_regs_address_in == `SFC_OFF_OCC) begin
          src_regs_readdata_out <= {8'h00, src_occ}; // RULE_20
        end else begin
          src_regs_readdata_out <= `SFC_UNMAPPED_VAL;
        end
      end
    end
  end

endmodule // sfc_stream_fifo

/* File: verification/sfc_sink_model.sv */
// Downstream stream consumer: prompt, slow (one cycle in four) or stalled
`timescale 1ns/1ps
module sfc_sink_model #(
  parameter DATA_W = 32
) (
  input  wire              core_clk_in,
  input  wire              srst_in,
  input  wire [1:0]        mode_in,
  input  wire              valid_in,
  input  wire [DATA_W-1:0] data_in,
  input  wire [7:0]        channel_in,
  input  wire              error_in,
  input  wire              eop_in,
  input  wire              sop_in,
  output reg               ready_out
);
  logic [DATA_W+10:0] got_q[$];
  reg   [1:0]         phase_q;
  always @(posedge core_clk_in) begin
    if (valid_in && ready_out && !srst_in) begin
      got_q.push_back({sop_in, eop_in, error_in, channel_in, data_in});
    end
    phase_q <= srst_in ? 2'h0 : phase_q + 2'h1;
    ready_out <= #1 !srst_in && (mode_in == 2'h0 || (mode_in == 2'h1 && phase_q == 2'h3));
  end
endmodule // sfc_sink_model

/* File: verification/sfc_stream_fifo_sva.sv */
// Assertion checker for the streaming buffer core
`timescale 1ns/1ps
`include "sfc_defs.vh"
module sfc_stream_fifo_sva #(
  parameter DATA_W = 32,
  parameter ADDR_W = 4
) (
  input wire                   core_clk_in,
  input wire                   srst_in,
  input wire                   sink_valid_in,
  input wire                   sink_ready_out,
  input wire                   sink_eop_in,
  input wire                   source_valid_out,
  input wire                   source_ready_in,
  input wire [DATA_W-1:0]      source_data_out,
  input wire                   source_eop_out,
  input wire [`SFC_ADDR_W-1:0] csr_address_in,
  input wire                   csr_read_in,
  input wire                   csr_write_in,
  input wire [`SFC_REG_W-1:0]  csr_writedata_in,
  input wire [`SFC_REG_W-1:0]  csr_readdata_out,
  input wire                   near_full_flag_out,
  input wire                   near_empty_flag_out
);
  reg [31:0] hwm_q;
  reg [31:0] lwm_q;
  reg [31:0] efc_q;
  reg [7:0]  eops_q;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  // Shadows of the thresholds; the eop count only errs high, so it never fires falsely
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      hwm_q  <= (32'h1 << ADDR_W) - 32'h1;
      lwm_q  <= 32'h0;
      efc_q  <= 32'h0;
      eops_q <= 8'h0;
    end else begin
      if (csr_write_in && csr_address_in == `SFC_OFF_HWM) hwm_q <= csr_writedata_in;
      if (csr_write_in && csr_address_in == `SFC_OFF_LWM) lwm_q <= csr_writedata_in;
      if (csr_write_in && csr_address_in == `SFC_OFF_EFC) efc_q <= csr_writedata_in;
      eops_q <= eops_q + {7'h0, sink_valid_in && sink_ready_out && sink_eop_in}
                - {7'h0, source_valid_out && source_ready_in && source_eop_out};
    end
  end
  a_src_hold_stall: assert property (source_valid_out && !source_ready_in |=>
    source_valid_out && $stable(source_data_out)) else $error("source beat changed in stall");
  a_occ_upper_zero: assert property (csr_read_in && csr_address_in == `SFC_OFF_OCC |=>
    csr_readdata_out[31:24] == 8'h0) else $error("occupancy upper bits set");
  a_rsvd_reads_zero: assert property (csr_read_in && csr_address_in == `SFC_OFF_RSVD |=>
    csr_readdata_out == 32'h0) else $error("reserved word not zero");
  a_hwm_write_read: assert property (csr_write_in && csr_address_in == `SFC_OFF_HWM ##1
    csr_read_in && csr_address_in == `SFC_OFF_HWM |=> csr_readdata_out == $past(csr_writedata_in, 2))
    else $error("high mark readback wrong");
  a_lwm_readback: assert property (csr_read_in && csr_address_in == `SFC_OFF_LWM |=>
    csr_readdata_out == lwm_q) else $error("low mark readback wrong");
  a_efc_readback: assert property (csr_read_in && csr_address_in == `SFC_OFF_EFC |=>
    csr_readdata_out == efc_q) else $error("forward count readback wrong");
  a_ready_fall_cause: assert property ($fell(sink_ready_out) |->
    $past(sink_valid_in && sink_ready_out)) else $error("ready fell without a taken beat");
  a_sf_wait_eop: assert property ($rose(source_valid_out) && efc_q == 32'h0 |->
    eops_q != 8'h0) else $error("valid before a whole packet stored");
  a_near_full_level: assert property (csr_read_in && csr_address_in == `SFC_OFF_OCC |=>
    near_full_flag_out == (csr_readdata_out[23:0] >= hwm_q)) else $error("near full wrong");
  a_near_empty_level: assert property (csr_read_in && csr_address_in == `SFC_OFF_OCC |=>
    near_empty_flag_out == (csr_readdata_out[23:0] <= lwm_q)) else $error("near empty wrong");
  c_packet_out: cover property (source_valid_out && source_ready_in && source_eop_out);
  c_full: cover property (!sink_ready_out);
  c_near_full: cover property ($rose(near_full_flag_out));
endmodule // sfc_stream_fifo_sva
bind sfc_stream_fifo sfc_stream_fifo_sva #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) sfc_stream_fifo_sva_i (
  .core_clk_in, .srst_in, .sink_valid_in, .sink_ready_out, .sink_eop_in, .source_valid_out,
  .source_ready_in, .source_data_out, .source_eop_out, .csr_address_in, .csr_read_in,
  .csr_write_in, .csr_writedata_in, .csr_readdata_out, .near_full_flag_out, .near_empty_flag_out);

/* File: verification/test_sfc_stream_fifo.sv */
// Self-checking bench for the streaming buffer core
`timescale 1ns/1ps
`include "sfc_defs.vh"
module test_sfc_stream_fifo;
  reg          core_clk_in, srst_in, snk_v, snk_sop, snk_eop, snk_err, rd, wr, srd, drd;
  reg   [31:0] snk_data, wdata;
  reg   [7:0]  snk_chan;
  reg   [2:0]  addr;
  reg   [1:0]  dn_mode;
  wire         snk_rdy, src_v, src_rdy, src_err, src_eop, src_sop, nf, ne;
  wire  [31:0] src_data, csr_q, snk_q, src_q;
  wire  [7:0]  src_chan;
  int          miscompares, num_checks;
  logic [42:0] exp_q[$];

  sfc_stream_fifo sfc_stream_fifo_i (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .sink_valid_in(snk_v), .sink_ready_out(snk_rdy), .sink_data_in(snk_data),
    .sink_channel_in(snk_chan), .sink_error_in(snk_err), .sink_sop_in(snk_sop),
    .sink_eop_in(snk_eop), .sink_empty_in(2'h0), .source_valid_out(src_v),
    .source_ready_in(src_rdy), .source_data_out(src_data), .source_channel_out(src_chan),
    .source_error_out(src_err), .source_sop_out(src_sop), .source_eop_out(src_eop),
    .source_empty_out(), .csr_address_in(addr), .csr_read_in(rd), .csr_write_in(wr),
    .csr_writedata_in(wdata), .csr_readdata_out(csr_q), .snk_regs_address_in(addr),
    .snk_regs_read_in(srd), .snk_regs_readdata_out(snk_q), .src_regs_address_in(addr),
    .src_regs_read_in(drd), .src_regs_readdata_out(src_q), .near_full_flag_out(nf),
    .near_empty_flag_out(ne));
  sfc_sink_model sfc_sink_model_i (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .mode_in(dn_mode), .valid_in(src_v), .data_in(src_data), .channel_in(src_chan),
    .error_in(src_err), .eop_in(src_eop), .sop_in(src_sop), .ready_out(src_rdy));

  task automatic check(input string what, input logic [42:0] exp, input logic [42:0] seen);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic timeout();
    miscompares++;
    $display("mismatch wait expected done seen timeout");
    complete_run();
  endtask
  task automatic csr_wr(input [2:0] a, input [31:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge core_clk_in) #1;
    wr = 1'b0;
  endtask
  // Port 0 is the main register port, 1 the sink-side and 2 the source-side port
  task automatic rd_chk(input string n, input [1:0] p, input [2:0] a, input [31:0] e);
    addr = a;
    {rd, srd, drd} = {p == 2'h0, p == 2'h1, p == 2'h2};
    @(posedge core_clk_in) #1;
    {rd, srd, drd} = 3'h0;
    @(posedge core_clk_in) #1;
    check(n, e, (p == 2'h0) ? csr_q : (p == 2'h1) ? snk_q : src_q);
  endtask
  // Leaves valid high so the next beat can follow back to back
  task automatic send(input [31:0] d, input [7:0] c, input e, input s, input l, input keep);
    int n;
    {snk_data, snk_chan, snk_err, snk_sop, snk_eop, snk_v} = {d, c, e, s, l, 1'b1};
    if (keep) exp_q.push_back({s, l, e, c, d});
    for (n = 0; !snk_rdy; n++) begin
      if (n == 200) timeout();
      @(posedge core_clk_in) #1;
    end
    @(posedge core_clk_in) #1;
  endtask
  task automatic idle(input int k);
    snk_v = 1'b0;
    repeat (k) @(posedge core_clk_in) #1;
  endtask
  task automatic drain(input string n);
    int i;
    for (i = 0; sfc_sink_model_i.got_q.size() < exp_q.size(); i++) begin
      if (i == 500) timeout();
      @(posedge core_clk_in) #1;
    end
    repeat (8) @(posedge core_clk_in) #1;
    check(n, exp_q.size(), sfc_sink_model_i.got_q.size());
    foreach (exp_q[j]) check(n, exp_q[j], sfc_sink_model_i.got_q[j]);
    exp_q.delete();
    sfc_sink_model_i.got_q.delete();
  endtask

  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  initial begin
    int k;
    {srst_in, snk_v, snk_sop, snk_eop, snk_err, rd, wr, srd, drd} = 9'h100;
    {snk_data, wdata, snk_chan, addr, dn_mode} = {32'h0, 32'h0, 8'h0, 3'h0, 2'h2};
    repeat (4) @(posedge core_clk_in);
    #1 srst_in = 1'b0;
    for (k = 0; k < 5; k++) rd_chk("reset word", 0, k[2:0], (k == 2) ? 32'hf : 32'h0);
    rd_chk("sink side occupancy", 1, `SFC_OFF_OCC, 32'h0);
    rd_chk("source side occupancy", 2, `SFC_OFF_OCC, 32'h0);
    check("near empty", 1'b1, ne);
    check("near full", 1'b0, nf);
    $display("test reset_values done");
    csr_wr(`SFC_OFF_RSVD, 32'hffff_ffff);
    rd_chk("reserved", 0, `SFC_OFF_RSVD, 32'h0);
    csr_wr(`SFC_OFF_OCC, 32'h0000_0005);
    rd_chk("occupancy read only", 0, `SFC_OFF_OCC, 32'h0);
    csr_wr(`SFC_OFF_HWM, 32'h0000_0006);
    rd_chk("high mark", 0, `SFC_OFF_HWM, 32'h6);
    csr_wr(`SFC_OFF_LWM, 32'h0000_0002);
    rd_chk("low mark", 0, `SFC_OFF_LWM, 32'h2);
    $display("test registers done");
    for (k = 0; k < 2; k++) send(32'ha0 + k, k * 50, 0, k == 0, 0, 1);
    idle(3);
    check("valid before packet end", 1'b0, src_v);
    rd_chk("occupancy", 0, `SFC_OFF_OCC, 32'h2);
    check("near empty at mark", 1'b1, ne);
    for (k = 2; k < 6; k++) send(32'ha0 + k, k * 50, k == 4, k == 3, k == 2 || k == 5, 1);
    idle(6);
    check("valid after packet end", 1'b1, src_v);
    rd_chk("occupancy", 0, `SFC_OFF_OCC, 32'h6);
    check("near full at mark", 1'b1, nf);
    check("near empty", 1'b0, ne);
    rd_chk("sink side occupancy", 1, `SFC_OFF_OCC, 32'h5);
    rd_chk("source side occupancy", 2, `SFC_OFF_OCC, 32'h6);
    dn_mode = 2'h1;
    drain("store and forward");
    $display("test store_and_forward done");
    csr_wr(`SFC_OFF_DISCARD, 32'h0000_0001);
    send(32'hb0, 8'h1, 1, 1, 0, 0);
    send(32'hb1, 8'h1, 0, 0, 1, 0);
    send(32'hb2, 8'h2, 0, 1, 1, 1);
    idle(1);
    drain("discard");
    csr_wr(`SFC_OFF_DISCARD, 32'h0);
    $display("test discard done");
    dn_mode = 2'h2;
    csr_wr(`SFC_OFF_EFC, 32'h0000_0003);
    for (k = 0; k < 2; k++) send(32'hc0 + k, 8'h7, 0, k == 0, 0, 1);
    idle(3);
    check("valid below count", 1'b0, src_v);
    send(32'hc2, 8'h7, 0, 0, 0, 1);
    idle(3);
    check("valid at count", 1'b1, src_v);
    dn_mode = 2'h0;
    idle(6);
    send(32'hc3, 8'h7, 0, 0, 0, 1);
    send(32'hc4, 8'h7, 0, 0, 1, 1);
    idle(1);
    drain("cut through");
    $display("test cut_through done");
    csr_wr(`SFC_OFF_EFC, 32'h0);
    rd_chk("forward count", 0, `SFC_OFF_EFC, 32'h0);
    dn_mode = 2'h2;
    for (k = 0; k < 17; k++) send(32'hd0 + k, 8'h3, 0, k == 0 || k == 16, k >= 15, 1);
    idle(2);
    check("ready when full", 1'b0, snk_rdy);
    rd_chk("occupancy full", 0, `SFC_OFF_OCC, 32'h11);
    dn_mode = 2'h1;
    drain("fill and drain");
    rd_chk("occupancy empty", 0, `SFC_OFF_OCC, 32'h0);
    check("near empty", 1'b1, ne);
    $display("test fill_and_drain done");
    complete_run();
  end
endmodule // test_sfc_stream_fifo
